// file: shared/line_trig_pkg.sv
package line_trig_pkg;

    // ----------------------------------------------------------------
    // Register map (byte addresses, one 32-bit word each)
    // ----------------------------------------------------------------
    localparam int ADDR_W = 6;
    localparam logic [5:0] OFF_CTRL = 6'h00;  // Control fields, see ctrl_t.
    localparam logic [5:0] OFF_EXPOSURE = 6'h04;  // Programmed exposure in us.
    localparam logic [5:0] OFF_UP = 6'h08;  // Up-scale factor.
    localparam logic [5:0] OFF_DOWN = 6'h0c;  // Down-scale factor.
    localparam logic [5:0] OFF_WINDOW = 6'h10;  // Jitter window select.
    localparam logic [5:0] OFF_FREE_PERIOD = 6'h14;  // Free-run period in cycles.
    localparam logic [5:0] OFF_WIDTH = 6'h18;  // Image width in pixels.
    localparam logic [5:0] OFF_STATUS = 6'h1c;  // Live state, read only.
    localparam logic [5:0] OFF_LINES = 6'h20;  // Accepted line count, read only.
    localparam logic [5:0] OFF_AVG = 6'h24;  // Averaged trigger period, read only.

    // ----------------------------------------------------------------
    // Field layout and reset values
    // ----------------------------------------------------------------
    localparam int CTRL_W = 9;
    localparam logic [1:0] EDGE_POS = 2'h0;  // positive_edge_setting
    localparam logic [1:0] EDGE_NEG = 2'h1;  // negative_edge_setting
    localparam logic [1:0] EDGE_BOTH = 2'h2;  // both_edges_setting
    localparam logic [8:0] CTRL_RST = 9'h000;
    localparam logic [15:0] EXP_RST = 16'h0064;
    localparam logic [10:0] SCALE_RST = 11'h001;
    localparam logic [2:0] WIN_RST = 3'h0;
    localparam logic [23:0] FREE_PERIOD_RST = 24'h002710;
    localparam logic [14:0] WIDTH_RST = 15'h1000;

    // ----------------------------------------------------------------
    // Limits and timing
    // ----------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 10;
    localparam int CLK_MHZ = 1000 / CLK_PERIOD_NS;
    localparam int CYC_PER_US = 1000 / CLK_PERIOD_NS;
    localparam int EXP_OFFSET_NS = 2460;
    localparam int EXP_OFFSET_CYC = (EXP_OFFSET_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [15:0] EXP_MIN_US = 16'h0001;
    localparam logic [15:0] EXP_MAX_US = 16'h03e8;
    localparam logic [15:0] SCALE_MIN = 16'h0001;
    localparam logic [15:0] SCALE_MAX = 16'h0400;
    localparam int WIN_LOG2_MIN = 4;
    localparam logic [2:0] WIN_SEL_MAX = 3'h5;
    localparam int PIX_FAST_MHZ = 85;
    localparam int PIX_SLOW_MHZ = 50;
    localparam int RO_FRAC = 6;
    localparam int RO_K_FAST = ((CLK_MHZ << RO_FRAC) + PIX_FAST_MHZ - 1) / PIX_FAST_MHZ;
    localparam int RO_K_SLOW = ((CLK_MHZ << RO_FRAC) + PIX_SLOW_MHZ - 1) / PIX_SLOW_MHZ;

    // Control word carried as one packed group.
    typedef struct packed {
        logic [1:0] tap_log2;   // Output lanes: 1, 2, 4 or 8.
        logic pix_slow;         // Readout pixel clock at the slower rate.
        logic scaler_en;        // rate_scaler in use.
        logic width_mode;       // Exposure follows the trigger pulse.
        logic [1:0] edge_sel;   // edge_select.
        logic ext_en;           // Lines started from external_trigger_pin.
        logic acq_run;          // Acquisition running.
    } ctrl_t;

    // Exposure sequencer states.
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_TIMED = 2'b01,
        ST_WIDTH = 2'b10
    } exp_state_t;

endpackage : line_trig_pkg

// file: hw/line_trigger_rescale_exposure.sv
`timescale 1ns/1ps
module line_trigger_rescale_exposure (
    input wire logic i_clk,
    input wire logic i_reset_n,
    input wire logic i_trig_pin,
    input wire logic [5:0] i_addr,
    input wire logic [31:0] i_wr_data,
    input wire logic i_wr_en,
    input wire logic i_rd_en,
    output logic [31:0] o_rd_data,
    output logic o_line_start,
    output logic o_exposing,
    output logic o_readout
);

    // ----------------------------------------------------------------
    // Register file
    // ----------------------------------------------------------------
    line_trig_pkg::ctrl_t ctrl_ff;  // Mode and edge selection.
    logic [15:0] exp_us_ff;  // Clamped exposure time in microseconds.
    logic [10:0] up_ff;  // Clamped up-scale factor.
    logic [10:0] down_ff;  // Clamped down-scale factor.
    logic [2:0] win_sel_ff;  // scaler_jitter_window, window_sixteen is zero.
    logic [23:0] free_period_ff;  // Free-run line period in cycles.
    logic [14:0] width_ff;  // Image width in pixels.
    logic [31:0] rd_data_ff;  // Read data, valid one cycle after the strobe.

    // Write clamps keep out-of-range settings from ever reaching the datapath.
    wire [15:0] wr_low = i_wr_data[15:0];
    wire [15:0] exp_clamp = (wr_low < line_trig_pkg::EXP_MIN_US) ? line_trig_pkg::EXP_MIN_US :
        (wr_low > line_trig_pkg::EXP_MAX_US) ? line_trig_pkg::EXP_MAX_US : wr_low;
    wire [15:0] scale_wide = (wr_low < line_trig_pkg::SCALE_MIN) ? line_trig_pkg::SCALE_MIN :
        (wr_low > line_trig_pkg::SCALE_MAX) ? line_trig_pkg::SCALE_MAX : wr_low;
    wire [10:0] scale_clamp = scale_wide[10:0];
    wire [2:0] win_clamp = (i_wr_data[2:0] > line_trig_pkg::WIN_SEL_MAX) ?
        line_trig_pkg::WIN_SEL_MAX : i_wr_data[2:0];

    wire wr_ctrl = i_wr_en && (i_addr == line_trig_pkg::OFF_CTRL);
    wire wr_exp = i_wr_en && (i_addr == line_trig_pkg::OFF_EXPOSURE);
    wire wr_up = i_wr_en && (i_addr == line_trig_pkg::OFF_UP);
    wire wr_down = i_wr_en && (i_addr == line_trig_pkg::OFF_DOWN);
    wire wr_win = i_wr_en && (i_addr == line_trig_pkg::OFF_WINDOW);
    wire wr_free = i_wr_en && (i_addr == line_trig_pkg::OFF_FREE_PERIOD);
    wire wr_width = i_wr_en && (i_addr == line_trig_pkg::OFF_WIDTH);

    // Configuration registers; exposure, scale and window take clamped values on a write, the rest take the raw field.
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            ctrl_ff <= line_trig_pkg::CTRL_RST;
            exp_us_ff <= line_trig_pkg::EXP_RST;
            up_ff <= line_trig_pkg::SCALE_RST;
            down_ff <= line_trig_pkg::SCALE_RST;
            win_sel_ff <= line_trig_pkg::WIN_RST;
            free_period_ff <= line_trig_pkg::FREE_PERIOD_RST;
            width_ff <= line_trig_pkg::WIDTH_RST;
        end else begin
            if (wr_ctrl) ctrl_ff <= i_wr_data[line_trig_pkg::CTRL_W-1:0];
            if (wr_exp) exp_us_ff <= exp_clamp;
            if (wr_up) up_ff <= scale_clamp;
            if (wr_down) down_ff <= scale_clamp;
            if (wr_win) win_sel_ff <= win_clamp;
            if (wr_free) free_period_ff <= i_wr_data[23:0];
            if (wr_width) width_ff <= i_wr_data[14:0];
        end
    end

    // ----------------------------------------------------------------
    // Trigger edge detection
    // ----------------------------------------------------------------
    logic pin_d_ff;  // Previous pin level; the pin is synchronous already.
    wire pin_rise = i_trig_pin && !pin_d_ff;
    wire pin_fall = !i_trig_pin && pin_d_ff;
    wire active_edge = (ctrl_ff.edge_sel == line_trig_pkg::EDGE_POS) ? pin_rise :
        (ctrl_ff.edge_sel == line_trig_pkg::EDGE_NEG) ? pin_fall :
        (pin_rise || pin_fall);

    // Delay stage for edge detection.
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            pin_d_ff <= 1'b0;
        end else begin
            pin_d_ff <= i_trig_pin;
        end
    end

    // ----------------------------------------------------------------
    // Rate scaler: period averaging
    // ----------------------------------------------------------------
    logic [23:0] per_cnt_ff;  // Cycles since the last active edge, saturating.
    logic [32:0] sum_ff;  // Period sum over the current window.
    logic [9:0] win_cnt_ff;  // Periods collected in the current window.
    logic seen_ff;  // A first edge has opened a period.
    logic [23:0] avg_ff;  // Averaged period in cycles.
    logic avg_valid_ff;  // At least one full window has been averaged.

    wire scaler_on = ctrl_ff.acq_run && ctrl_ff.ext_en && ctrl_ff.scaler_en;
    wire [3:0] win_shift = 4'(line_trig_pkg::WIN_LOG2_MIN) + {1'b0, win_sel_ff};
    wire [9:0] win_last = 10'((11'h001 << win_shift) - 11'h001);
    wire [32:0] sum_next = sum_ff + {9'h000, per_cnt_ff};
    wire [32:0] avg_wide = sum_next >> win_shift;
    wire window_done = scaler_on && active_edge && seen_ff && (win_cnt_ff == win_last);
    wire per_sat = &per_cnt_ff;

    // Only a whole window updates the average, so one late encoder pulse moves the
    // line pitch by a fraction of a line instead of a full line.
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            per_cnt_ff <= 24'h000000;
            sum_ff <= 33'h000000000;
            win_cnt_ff <= 10'h000;
            seen_ff <= 1'b0;
            avg_ff <= 24'h000000;
            avg_valid_ff <= 1'b0;
        end else if (!scaler_on) begin
            per_cnt_ff <= 24'h000000;
            sum_ff <= 33'h000000000;
            win_cnt_ff <= 10'h000;
            seen_ff <= 1'b0;
            avg_valid_ff <= 1'b0;
        end else if (active_edge) begin
            per_cnt_ff <= 24'h000001;
            seen_ff <= 1'b1;
            if (window_done) begin
                avg_ff <= avg_wide[23:0];
                avg_valid_ff <= 1'b1;
                sum_ff <= 33'h000000000;
                win_cnt_ff <= 10'h000;
            end else if (seen_ff) begin
                sum_ff <= sum_next;
                win_cnt_ff <= win_cnt_ff + 10'h001;
            end
        end else if (!per_sat) begin
            per_cnt_ff <= per_cnt_ff + 24'h000001;
        end
    end

    // ----------------------------------------------------------------
    // Rate scaler: evenly spaced trigger synthesis
    // ----------------------------------------------------------------
    // A phase accumulator gains up_ff per cycle and fires each time it passes
    // avg * down, giving up/down lines per averaged period without a divider.
    logic [35:0] acc_ff;  // Phase accumulator.
    wire [34:0] thresh = avg_ff * down_ff;
    wire [35:0] acc_sum = acc_ff + {25'h0000000, up_ff};
    wire dda_fire = avg_valid_ff && (acc_sum >= {1'b0, thresh});
    wire [35:0] acc_next = dda_fire ? (acc_sum - {1'b0, thresh}) : acc_sum;

    // The accumulator only runs once an average exists.
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            acc_ff <= 36'h000000000;
        end else if (!avg_valid_ff) begin
            acc_ff <= 36'h000000000;
        end else begin
            acc_ff <= acc_next;
        end
    end

    // ----------------------------------------------------------------
    // Free-run trigger generator
    // ----------------------------------------------------------------
    logic [23:0] free_cnt_ff;  // Cycles into the current free-run period.
    wire free_on = ctrl_ff.acq_run && !ctrl_ff.ext_en;
    wire free_fire = free_on && (free_cnt_ff >= (free_period_ff - 24'h000001));

    // Counts whole periods; a period below the line time just saturates the rate.
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            free_cnt_ff <= 24'h000000;
        end else if (!free_on || free_fire) begin
            free_cnt_ff <= 24'h000000;
        end else begin
            free_cnt_ff <= free_cnt_ff + 24'h000001;
        end
    end

    // ----------------------------------------------------------------
    // Line acceptance
    // ----------------------------------------------------------------
    line_trig_pkg::exp_state_t state_ff;  // Exposure sequencer state.
    line_trig_pkg::exp_state_t nxt_state;
    logic exposing_ff;  // Sensor is integrating.
    logic [16:0] exp_cnt_ff;  // Remaining cycles of a timed exposure.
    logic [16:0] ro_cnt_ff;  // Remaining readout cycles of the previous line.
    logic line_start_ff;  // One-cycle pulse per accepted line.
    logic start_level_ff;  // Pin level right after the starting edge.
    logic [31:0] lines_ff;  // Accepted lines.
    logic [15:0] overrun_ff;  // Triggers dropped because the sensor was busy.
    logic readout_ff;  // Readout timer running, registered so the pin has no glitches.

    wire ext_trig = ctrl_ff.scaler_en ? dda_fire : active_edge;
    wire trig_req = ctrl_ff.acq_run && (ctrl_ff.ext_en ? ext_trig : free_fire);
    // A new line waits for both exposure and readout to finish.
    wire busy = exposing_ff || (ro_cnt_ff != 17'h00000);
    wire accept = trig_req && !busy;
    // Pulse mode needs a real pulse, so scaled triggers always use timed exposure.
    wire use_width = ctrl_ff.ext_en && ctrl_ff.width_mode && !ctrl_ff.scaler_en;

    // Programmed time plus the fixed pad, in cycles.
    wire [16:0] exp_cyc = 17'(exp_us_ff * 16'(line_trig_pkg::CYC_PER_US))
        + 17'(line_trig_pkg::EXP_OFFSET_CYC);

    // Readout time scales with width over lane count at the selected pixel clock.
    wire [7:0] ro_k = ctrl_ff.pix_slow ? 8'(line_trig_pkg::RO_K_SLOW) :
        8'(line_trig_pkg::RO_K_FAST);
    wire [14:0] px_per_lane = width_ff >> ctrl_ff.tap_log2;
    wire [22:0] ro_prod = px_per_lane * ro_k;
    wire [16:0] ro_cyc = ro_prod[22:line_trig_pkg::RO_FRAC];

    wire width_end = (state_ff == line_trig_pkg::ST_WIDTH) && (i_trig_pin != start_level_ff);
    wire timed_end = (state_ff == line_trig_pkg::ST_TIMED) && (exp_cnt_ff == 17'h00000);
    wire exp_end = width_end || timed_end;

    // Next-state choice for the exposure sequencer.
    always_comb begin
        nxt_state = state_ff;
        unique case (state_ff)
            line_trig_pkg::ST_IDLE: begin
                if (accept) begin
                    nxt_state = use_width ? line_trig_pkg::ST_WIDTH : line_trig_pkg::ST_TIMED;
                end
            end
            line_trig_pkg::ST_TIMED: begin
                if (timed_end) nxt_state = line_trig_pkg::ST_IDLE;
            end
            line_trig_pkg::ST_WIDTH: begin
                // No counter here: the pulse alone decides the length.
                if (width_end) nxt_state = line_trig_pkg::ST_IDLE;
            end
            default: begin
                nxt_state = line_trig_pkg::ST_IDLE;
            end
        endcase
    end

    // Exposure sequencer, readout timer and line bookkeeping.
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            state_ff <= line_trig_pkg::ST_IDLE;
            exposing_ff <= 1'b0;
            exp_cnt_ff <= 17'h00000;
            ro_cnt_ff <= 17'h00000;
            line_start_ff <= 1'b0;
            start_level_ff <= 1'b0;
            lines_ff <= 32'h00000000;
            overrun_ff <= 16'h0000;
            readout_ff <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            line_start_ff <= accept;
            readout_ff <= !accept && (exp_end ? (|ro_cyc) : (ro_cnt_ff > 17'h00001));
            if (accept) begin
                exposing_ff <= 1'b1;
                exp_cnt_ff <= exp_cyc - 17'h00001;
                start_level_ff <= i_trig_pin;
                lines_ff <= lines_ff + 32'h00000001;
            end else if (exp_end) begin
                exposing_ff <= 1'b0;
                ro_cnt_ff <= ro_cyc;
            end else begin
                if (exp_cnt_ff != 17'h00000) exp_cnt_ff <= exp_cnt_ff - 17'h00001;
                if (ro_cnt_ff != 17'h00000) ro_cnt_ff <= ro_cnt_ff - 17'h00001;
            end
            if (trig_req && busy && !(&overrun_ff)) overrun_ff <= overrun_ff + 16'h0001;
        end
    end

    // ----------------------------------------------------------------
    // Read path
    // ----------------------------------------------------------------
    wire [31:0] status_word = {overrun_ff, 11'h000, avg_valid_ff, o_readout,
        exposing_ff, state_ff};
    wire [31:0] rd_mux =
        (i_addr == line_trig_pkg::OFF_CTRL) ? {23'h000000, ctrl_ff} :
        (i_addr == line_trig_pkg::OFF_EXPOSURE) ? {16'h0000, exp_us_ff} :
        (i_addr == line_trig_pkg::OFF_UP) ? {21'h000000, up_ff} :
        (i_addr == line_trig_pkg::OFF_DOWN) ? {21'h000000, down_ff} :
        (i_addr == line_trig_pkg::OFF_WINDOW) ? {29'h00000000, win_sel_ff} :
        (i_addr == line_trig_pkg::OFF_FREE_PERIOD) ? {8'h00, free_period_ff} :
        (i_addr == line_trig_pkg::OFF_WIDTH) ? {17'h00000, width_ff} :
        (i_addr == line_trig_pkg::OFF_STATUS) ? status_word :
        (i_addr == line_trig_pkg::OFF_LINES) ? lines_ff :
        (i_addr == line_trig_pkg::OFF_AVG) ? {8'h00, avg_ff} : 32'h00000000;

    // Read data stands only in the cycle after the strobe.
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            rd_data_ff <= 32'h00000000;
        end else begin
            rd_data_ff <= i_rd_en ? rd_mux : 32'h00000000;
        end
    end

    assign o_rd_data = rd_data_ff;
    assign o_line_start = line_start_ff;
    assign o_exposing = exposing_ff;
    assign o_readout = readout_ff;

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    logic [16:0] exp_len_ff;  // Helper: cycles the current exposure has lasted.
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            exp_len_ff <= 17'h00000;
        end else begin
            exp_len_ff <= exposing_ff ? exp_len_ff + 17'h00001 : 17'h00000;
        end
    end

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_reset_n);

    chk_line_on_edge: assert property (
        ctrl_ff.acq_run && ctrl_ff.ext_en && !ctrl_ff.scaler_en && active_edge && !busy
        |=> o_line_start && o_exposing) else $error("edge did not start a line");
    chk_timed_length: assert property (
        (state_ff == line_trig_pkg::ST_TIMED) && timed_end |-> exp_len_ff + 17'h00001 == exp_cyc)
        else $error("timed exposure length wrong");
    chk_width_stop: assert property (
        width_end && !accept |=> !o_exposing) else $error("pulse exposure did not end");
    chk_busy_block: assert property (
        o_line_start |-> $past(!exposing_ff) && $past(ro_cnt_ff) == 17'h00000)
        else $error("line started while busy");
    chk_readout_load: assert property (
        exp_end && !accept |=> ro_cnt_ff == $past(ro_cyc)) else $error("readout time not loaded");
    chk_free_spacing: assert property (
        free_fire && free_on ##1 free_on |-> free_cnt_ff == 24'h000000)
        else $error("free-run period not restarted");
    chk_exp_range: assert property (
        exp_us_ff >= line_trig_pkg::EXP_MIN_US && exp_us_ff <= line_trig_pkg::EXP_MAX_US)
        else $error("exposure setting out of range");
    chk_scale_range: assert property (
        up_ff != 11'h000 && down_ff != 11'h000 && up_ff <= 11'h400 && down_ff <= 11'h400)
        else $error("scale factor out of range");
    chk_window_avg: assert property (
        window_done |=> avg_valid_ff && avg_ff == $past(avg_wide[23:0]))
        else $error("window average not stored");
    chk_unmapped_zero: assert property (
        i_rd_en && (i_addr > line_trig_pkg::OFF_AVG) |=> o_rd_data == 32'h00000000)
        else $error("unmapped read not zero");

    cov_width_exposure: cover property (accept && use_width ##[1:50] width_end);
    cov_scaled_line: cover property (scaler_on && dda_fire && accept);
    cov_overrun: cover property (trig_req && busy);
    cov_free_line: cover property (free_fire ##1 o_line_start);

endmodule : line_trigger_rescale_exposure

// file: verif/trig_source_model.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Trigger source: sends one pulse away from its idle level on request.
// ----------------------------------------------------------------
module trig_source_model (
    input wire logic i_clk,
    input wire logic i_reset_n,
    input wire logic i_start,
    input wire logic i_idle,
    input wire logic [15:0] i_width,
    output logic o_pin
);
    logic [15:0] cnt_ff; // Cycles left in the active part of the pulse.
    // The pulse width is exact, so equal widths give an even duty square wave.
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            cnt_ff <= 16'h0000;
        end else if (i_start) begin
            cnt_ff <= i_width;
        end else if (cnt_ff != 16'h0000) begin
            cnt_ff <= cnt_ff - 16'h0001;
        end
    end
    // A single-edge selection is used whenever the scaler would be in play.
    assign o_pin = (cnt_ff != 16'h0000) ? !i_idle : i_idle;
endmodule : trig_source_model

// file: verif/tb_top.sv
`timescale 1ns/1ps
module tb_top;
    logic i_clk, i_reset_n, trig_pin, i_wr_en, i_rd_en, src_start, src_idle;
    logic [5:0] i_addr;
    logic [31:0] i_wr_data, o_rd_data, rd_val;
    logic o_line_start, o_exposing, o_readout;
    logic [15:0] src_width;
    int miscompares = 0;
    int cmp_count = 0;
    int n;
    line_trigger_rescale_exposure dut_u (.i_clk(i_clk), .i_reset_n(i_reset_n),
        .i_trig_pin(trig_pin), .i_addr(i_addr), .i_wr_data(i_wr_data), .i_wr_en(i_wr_en),
        .i_rd_en(i_rd_en), .o_rd_data(o_rd_data), .o_line_start(o_line_start),
        .o_exposing(o_exposing), .o_readout(o_readout));
    trig_source_model src_u (.i_clk(i_clk), .i_reset_n(i_reset_n), .i_start(src_start),
        .i_idle(src_idle), .i_width(src_width), .o_pin(trig_pin));
    // ----------------------------------------------------------------
    // Clock, shared tasks and verdict.
    // ----------------------------------------------------------------
    initial begin
        i_clk = 1'b0;
        forever #5 i_clk = ~i_clk;
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            miscompares++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic wr(input logic [5:0] a, input logic [31:0] d);
        @(posedge i_clk); i_addr <= a; i_wr_data <= d; i_wr_en <= 1'b1;
        @(posedge i_clk); i_wr_en <= 1'b0;
    endtask : wr
    // Read data stand only in the cycle after the strobe, so sample mid-cycle.
    task automatic rd(input logic [5:0] a, output logic [31:0] d);
        @(posedge i_clk); i_addr <= a; i_rd_en <= 1'b1;
        @(posedge i_clk); i_rd_en <= 1'b0;
        @(negedge i_clk); d = o_rd_data;
    endtask : rd
    task automatic fire(input logic [15:0] w);
        @(posedge i_clk); src_width <= w; src_start <= 1'b1;
        @(posedge i_clk); src_start <= 1'b0;
    endtask : fire
    // Waits for a line start under a bound, then counts exposing cycles.
    task automatic expo(output int len);
        for (len = 0; len < 5000 && o_line_start !== 1'b1; len++) @(negedge i_clk);
        for (len = 0; len < 5000 && o_exposing === 1'b1; len++) @(negedge i_clk);
    endtask : expo
    task automatic complete_run;
        $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : complete_run
    // ----------------------------------------------------------------
    // Scenarios.
    // ----------------------------------------------------------------
    task automatic t_regs;
        rd(6'h04, rd_val); chk(rd_val, 32'h00000064);
        rd(6'h14, rd_val); chk(rd_val, 32'h00002710);
        wr(6'h04, 32'h00000000); rd(6'h04, rd_val); chk(rd_val, 32'h00000001);
        wr(6'h04, 32'h000007d0); rd(6'h04, rd_val); chk(rd_val, 32'h000003e8);
        wr(6'h0c, 32'h00000800); rd(6'h0c, rd_val); chk(rd_val, 32'h00000400);
        wr(6'h20, 32'h0000ffff); rd(6'h20, rd_val); chk(rd_val, 32'h00000000);
        rd(6'h3c, rd_val); chk(rd_val, 32'h00000000);
    endtask : t_regs
    // Measures the gap between two accepted lines.
    task automatic gap(output int g);
        for (g = 0; g < 5000 && o_line_start !== 1'b1; g++) @(negedge i_clk);
        @(negedge i_clk);
        for (g = 1; g < 5000 && o_line_start !== 1'b1; g++) @(negedge i_clk);
    endtask : gap
    // Timed exposure lasts the programmed time plus the fixed pad, then readout runs.
    task automatic t_timed(input logic [31:0] c, input int ro);
        wr(6'h00, c); fire(16'd400); expo(n);
        chk(n, line_trig_pkg::CYC_PER_US + line_trig_pkg::EXP_OFFSET_CYC);
        for (n = 0; n < 5000 && o_readout === 1'b1; n++) @(negedge i_clk);
        chk(n, ro);
        repeat (600) @(posedge i_clk);
    endtask : t_timed
    // One long pulse gives one line per selected edge; both edges give two.
    task automatic t_edges;
        for (int e = 0; e < 3; e++) begin
            wr(6'h00, 32'h00000183 | (e << 2)); fire(16'd400); n = 0;
            repeat (900) @(negedge i_clk) if (o_line_start === 1'b1) n++;
            chk(n, (e == 2) ? 2 : 1);
        end
    endtask : t_edges
    // Exposure follows the pulse, both above and below the timed length, for either polarity.
    task automatic t_pulse;
        wr(6'h00, 32'h00000193); fire(16'd700); expo(n); chk(n, 700);
        wr(6'h00, 32'h00000000); src_idle <= 1'b1; repeat (20) @(posedge i_clk);
        wr(6'h00, 32'h00000197); fire(16'd200); expo(n); chk(n, 200);
        repeat (100) @(posedge i_clk);
    endtask : t_pulse
    // Free run spacing equals the programmed period when the line is short.
    task automatic t_free;
        wr(6'h14, 32'd500); wr(6'h00, 32'h00000181);
        gap(n); chk(n, 500);
        wr(6'h00, 32'h00000000);
    endtask : t_free
    // A steady encoder of period 800 doubled by the scaler gives lines 400 apart.
    task automatic t_scale;
        wr(6'h08, 32'd2); wr(6'h0c, 32'd1); wr(6'h10, 32'd0);
        wr(6'h00, 32'h000001a3);
        for (int i = 0; i < 17; i++) begin
            fire(16'd20); repeat (798) @(posedge i_clk);
        end
        rd(6'h24, rd_val); chk(rd_val, 800);
        gap(n); chk(n, 800 * 1 / 2);
        wr(6'h00, 32'h00000000);
    endtask : t_scale
    initial begin
        i_reset_n = 1'b0; i_addr = 6'h00; i_wr_data = 32'h0; i_wr_en = 1'b0; i_rd_en = 1'b0;
        src_start = 1'b0; src_idle = 1'b0; src_width = 16'h0;
        repeat (12) @(posedge i_clk);
        i_reset_n <= 1'b1;
        t_regs;
        wr(6'h04, 32'h1); wr(6'h18, 32'd64);
        t_timed(32'h00000183, ((64 >> 3) * line_trig_pkg::RO_K_FAST) >> line_trig_pkg::RO_FRAC);
        t_timed(32'h00000143, ((64 >> 2) * line_trig_pkg::RO_K_SLOW) >> line_trig_pkg::RO_FRAC);
        t_edges; t_pulse; t_free; t_scale;
        complete_run;
    end
    // Cuts a hang short well beyond the expected run length.
    initial begin
        #500000;
        miscompares++;
        complete_run;
    end
endmodule : tb_top
